// *** pkg/memsup_pkg.sv ***
// shared constants and carriers for the memory support port strap loader
`default_nettype none
package memsup_pkg;
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned SK_HALF_NS      = 1000;   // least half period of the serial rom clock
  localparam int unsigned SK_HALF_CYC     = (SK_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned ROM_WORDS       = 16;     // words read from the serial rom
  localparam int unsigned ROM_AW          = 4;
  localparam int unsigned ACCESS_CYC      = 5;      // strobe length covers the pin synchroniser
  localparam logic [2:0]  ROM_READ_OP     = 3'h6;   // start bit plus read opcode
  localparam int unsigned BIT_SO          = 0;      // serial data out on data bit 0
  localparam int unsigned BIT_SI          = 1;      // serial data in on data bit 1
  localparam int unsigned BIT_SK          = 2;      // shift clock on data bit 2
  localparam logic [7:0]  STRAP_RESET     = 8'h00;
  localparam logic [15:0] WORD_RESET      = 16'h0000;

  typedef struct packed {
    logic [7:0] bank_a;
    logic [7:0] bank_b;
    logic [7:0] bank_c;
  } strap_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic        boot;    // access targets the boot rom
    logic        wide;    // 16-bit memory
    logic        compat;  // compatible address mode
    logic [15:0] addr;    // byte address
    logic [15:0] wdata;
  } mem_req_type;
endpackage
`default_nettype wire

// *** hdl/memsup_port.sv ***
// memory support port: strap capture, serial rom load and external memory strobes
// Operation
// RULE1 - outside reset the low data byte serves buffer ram and boot rom
// RULE2 - during reset low data byte captured into strap bank a, pull-up reads one
// RULE3 - on reset release read the serial rom over three data lines
// RULE4 - loaded rom words are readable by the host at the rom window
// RULE5 - after the rom read data bits 0, 1 and 2 return to bus duty
// RULE6 - outside reset the high data byte serves buffer ram
// RULE7 - during reset high data byte captured into strap bank b
// RULE8 - during reset lower eight address lines captured into strap bank c
// RULE9 - outside reset drive address bits 1 to 15, sample straps only in reset
// RULE10 - 8-bit memory puts byte address bit 0 on line 13 or 15
// RULE11 - read strobe moves ram data into the device
// RULE12 - write strobe moves device data into ram
// RULE13 - boot rom select asserted on every boot rom access
// RULE14 - separate ram selects for the low and high data halves
// RULE15 - serial rom select asserted while reading the serial rom after reset
// RULE16 - board ties the load-from-serial-rom input high to enable the load
// RULE17 - data lines undriven in reset, straps held until the next reset
// RULE18 - data lines driven only during write strobes; the code also drives data bits 0 and 2 while reading the serial rom
`default_nettype none
module memsup_port
  import memsup_pkg::*;
#(
  parameter int unsigned HALF_CYC = SK_HALF_CYC,
  parameter int unsigned WORDS    = ROM_WORDS
) (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  // board pins
  input  wire logic        LOAD_CFG_FROM_SERIAL_ROM,
  input  wire logic [15:0] MEM_DATA_IN,
  output logic      [15:0] MEM_DATA_OUT,
  output logic      [15:0] MEM_DATA_OE,
  input  wire logic [7:0]  MEM_ADDR_LOW_IN,
  output logic      [7:0]  MEM_ADDR_LOW_LINES,
  output logic             MEM_ADDR_LOW_OE,
  output logic      [6:0]  MEM_ADDR_HIGH_LINES,
  output logic             MEM_READ_STROBE,
  output logic             MEM_WRITE_STROBE,
  output logic             BOOT_ROM_SELECT,
  output logic             RAM_SELECT_LOW_HALF,
  output logic             RAM_SELECT_HIGH_HALF,
  output logic             SERIAL_ROM_SELECT,
  // core side
  input  wire mem_req_type MEM_REQ,
  output logic             MEM_READY,
  output logic             MEM_DONE,
  output logic      [15:0] MEM_RDATA,
  output strap_type        STRAPS,
  output logic             ROM_LOADED,
  input  wire logic [3:0]  ROM_INDEX,
  output logic      [15:0] ROM_WORD
);
  typedef enum {S_RESET, S_CMD, S_ADDR, S_DATA, S_IDLE, S_ACCESS} state_type;

  // synchronisers for pins: three stages, change accepted when stages two and three agree
  logic [24:0] sync1, sync2, sync3, pins_stable, next_pins_stable;
  logic [24:0] pins_raw;
  assign pins_raw = {LOAD_CFG_FROM_SERIAL_ROM, MEM_ADDR_LOW_IN, MEM_DATA_IN};

  always_comb begin
    next_pins_stable = pins_stable;
    for (int i = 0; i < 25; i++) begin
      if (sync2[i] == sync3[i]) next_pins_stable[i] = sync3[i];
    end
  end

  always_ff @(posedge CLK) begin
    if (CE) begin
      sync1       <= pins_raw;
      sync2       <= sync1;
      sync3       <= sync2;
      pins_stable <= next_pins_stable;
    end
  end

  logic [15:0] data_s;
  logic [7:0]  addr_s;
  logic        load_s;
  assign data_s = pins_stable[15:0];
  assign addr_s = pins_stable[23:16];
  assign load_s = pins_stable[24];

  // byte lane address mapping used only for the address line outputs
  function automatic logic [15:1] map_addr(input mem_req_type r);
    logic [15:1] a;
    a = r.addr[15:1];
    if (!r.wide) begin
      if (r.compat) a[13] = r.addr[0]; // [RULE10]
      else          a[15] = r.addr[0]; // [RULE10]
    end
    return a;
  endfunction

  state_type   state, next_state;
  strap_type   straps, next_straps;
  logic [15:0] rom [WORDS];
  logic [15:0] shift, next_shift;
  logic [15:0] wr_word;
  logic        wr_en;
  logic [3:0]  word_idx, next_word_idx;
  logic [4:0]  bit_cnt, next_bit_cnt;
  logic [15:0] half_cnt, next_half_cnt;
  logic        sk, next_sk, so, next_so;
  logic        loaded, next_loaded;
  mem_req_type req, next_req;
  logic [15:0] rdata, next_rdata;
  logic        done, next_done;

  // sequencer: strap capture, rom fetch, then memory accesses of fixed length
  always_comb begin
    next_state    = state;
    next_straps   = straps;
    next_shift    = shift;
    next_word_idx = word_idx;
    next_bit_cnt  = bit_cnt;
    next_half_cnt = half_cnt;
    next_sk       = sk;
    next_so       = so;
    next_loaded   = loaded;
    next_req      = req;
    next_rdata    = rdata;
    next_done     = 1'b0;
    wr_en         = 1'b0;
    wr_word       = {shift[14:0], data_s[BIT_SI]};
    case (state)
      S_RESET: begin
        // first enabled edge after reset: fetch the serial rom only when the board asks
        next_state = load_s ? S_CMD : S_IDLE; // [RULE3] [RULE16]
      end
      S_CMD, S_ADDR, S_DATA: begin
        if (half_cnt != 16'h0000) begin
          next_half_cnt = half_cnt - 16'h0001;
        end else begin
          next_half_cnt = 16'(HALF_CYC - 1);
          next_sk       = ~sk;
          if (!sk && state == S_DATA) begin
            // rising edge: sample serial data in, the last bit completes the word
            next_shift = wr_word; // [RULE3]
            wr_en      = (bit_cnt == 5'h00); // [RULE3]
          end else if (sk && bit_cnt != 5'h00) begin
            // falling edge: step to the next bit of the field
            next_bit_cnt = bit_cnt - 5'h01;
          end else if (sk) begin
            // falling edge after a field's last bit, so the shift clock ends low
            if (state == S_CMD) begin
              next_state   = S_ADDR;
              next_bit_cnt = 5'(ROM_AW - 1);
            end else if (state == S_ADDR) begin
              next_state   = S_DATA;
              next_bit_cnt = 5'h0F;
            end else if (word_idx == 4'(WORDS - 1)) begin
              next_state  = S_IDLE; // [RULE5]
              next_loaded = 1'b1;
            end else begin
              next_word_idx = word_idx + 4'h1;
              next_state    = S_CMD;
              next_bit_cnt  = 5'h02;
            end
          end
        end
      end
      S_IDLE: begin
        if (MEM_REQ.read || MEM_REQ.write) begin
          next_req      = MEM_REQ;
          next_half_cnt = 16'(ACCESS_CYC - 1);
          next_state    = S_ACCESS;
        end
      end
      S_ACCESS: begin
        // strobe held until the read data has crossed the pin synchroniser
        if (half_cnt != 16'h0000) begin
          next_half_cnt = half_cnt - 16'h0001;
        end else begin
          if (req.read) next_rdata = data_s; // [RULE11]
          next_done  = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // serial out is set up a whole half period before the rising edge that takes it
    if (next_state == S_CMD) next_so = ROM_READ_OP[next_bit_cnt[1:0]];
    else if (next_state == S_ADDR) next_so = next_word_idx[next_bit_cnt[1:0]];
    else next_so = 1'b0;
  end

  // registers; reset keeps capturing straps every cycle it is held
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state    <= S_RESET;
      straps   <= '{bank_a: data_s[7:0], bank_b: data_s[15:8], bank_c: addr_s}; // [RULE2] [RULE7] [RULE8]
      shift    <= WORD_RESET;
      word_idx <= 4'h0;
      bit_cnt  <= 5'h02;
      half_cnt <= 16'(HALF_CYC - 1);
      sk       <= 1'b0;
      so       <= 1'b0;
      loaded   <= 1'b0;
      req      <= '0;
      rdata    <= WORD_RESET;
      done     <= 1'b0;
    end else if (CE) begin
      // enabled edge: every group takes its next value
      state    <= next_state;
      straps   <= next_straps; // [RULE17]
      shift    <= next_shift;
      word_idx <= next_word_idx;
      bit_cnt  <= next_bit_cnt;
      half_cnt <= next_half_cnt;
      sk       <= next_sk;
      so       <= next_so;
      loaded   <= next_loaded;
      req      <= next_req;
      rdata    <= next_rdata;
      done     <= next_done;
    end
  end

  // rom image storage, no reset needed: gated by the loaded flag
  always_ff @(posedge CLK) begin
    if (CE && RSTN && wr_en) rom[word_idx] <= wr_word;
  end

  logic rom_phase, acc;
  assign rom_phase = (state == S_CMD) || (state == S_ADDR) || (state == S_DATA);
  assign acc       = (state == S_ACCESS);

  // pin drive: nothing during reset, serial lines during fetch, write data only during write strobes
  always_comb begin
    MEM_DATA_OUT = 16'h0000;
    MEM_DATA_OE  = 16'h0000; // [RULE17]
    if (rom_phase) begin
      MEM_DATA_OUT[BIT_SO] = so;
      MEM_DATA_OUT[BIT_SK] = sk;
      MEM_DATA_OE[BIT_SO]  = 1'b1;
      MEM_DATA_OE[BIT_SK]  = 1'b1;
    end else if (acc && req.write && !req.read) begin
      // a read wins, so the bus stays released; boot rom sits on the low byte only
      MEM_DATA_OUT = req.wdata; // [RULE12]
      MEM_DATA_OE  = (req.wide && !req.boot) ? 16'hFFFF : 16'h00FF; // [RULE18] [RULE1] [RULE6]
    end
  end

  logic [15:1] a_map;
  assign a_map               = map_addr(req);
  assign MEM_ADDR_LOW_LINES  = a_map[8:1]; // [RULE9]
  assign MEM_ADDR_HIGH_LINES = a_map[15:9]; // [RULE9]
  assign MEM_ADDR_LOW_OE     = (state != S_RESET); // straps sampled only in reset [RULE9]
  assign MEM_READ_STROBE     = acc && req.read; // [RULE11]
  assign MEM_WRITE_STROBE    = acc && req.write && !req.read; // [RULE12]
  assign BOOT_ROM_SELECT     = acc && req.boot; // [RULE13]
  assign RAM_SELECT_LOW_HALF  = acc && !req.boot; // [RULE14]
  assign RAM_SELECT_HIGH_HALF = acc && !req.boot && req.wide; // [RULE14]
  assign SERIAL_ROM_SELECT   = rom_phase; // [RULE15]
  assign MEM_READY           = (state == S_IDLE);
  assign MEM_DONE            = done;
  assign MEM_RDATA           = rdata;
  assign STRAPS              = straps;
  assign ROM_LOADED          = loaded;
  assign ROM_WORD            = loaded ? rom[ROM_INDEX] : WORD_RESET; // [RULE4]
endmodule
`default_nettype wire

// *** tb/memsup_port_properties.sv ***
// concurrent checks on the memory support port pins
`default_nettype none
module memsup_port_properties
  import memsup_pkg::*;
(
  // watched ports
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        CE,
  input wire mem_req_type MEM_REQ,
  input wire logic        MEM_READY,
  input wire logic        MEM_DONE,
  input wire logic [15:0] MEM_DATA_OE,
  input wire logic [7:0]  MEM_ADDR_LOW_LINES,
  input wire logic [6:0]  MEM_ADDR_HIGH_LINES,
  input wire logic        MEM_READ_STROBE,
  input wire logic        MEM_WRITE_STROBE,
  input wire logic        BOOT_ROM_SELECT,
  input wire logic        RAM_SELECT_LOW_HALF,
  input wire logic        RAM_SELECT_HIGH_HALF,
  input wire logic        SERIAL_ROM_SELECT,
  input wire logic        ROM_LOADED,
  input wire strap_type   STRAPS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // a request counts only on an enabled edge while ready; read wins over write
  wire logic take = CE && MEM_READY && (MEM_REQ.read || MEM_REQ.write);
  wire logic rd_take = CE && MEM_READY && MEM_REQ.read;

  a_reset_release: assert property ($rose(RSTN) |-> MEM_DATA_OE == 16'h0000 && !MEM_READY)
    else $error("bus driven at reset release");
  a_straps_hold: assert property ($past(RSTN) |-> $stable(STRAPS))
    else $error("straps changed outside reset");
  a_byte_line: assert property (take |=> MEM_ADDR_LOW_LINES == $past(MEM_REQ.addr[8:1])
    && ($past(MEM_REQ.wide) || ($past(MEM_REQ.compat) ? MEM_ADDR_HIGH_LINES[4]
    : MEM_ADDR_HIGH_LINES[6]) == $past(MEM_REQ.addr[0])))
    else $error("address lines wrong");
  // the strobe stands for the five access cycles, then done follows
  a_read_cycle: assert property (rd_take |=>
    (MEM_READ_STROBE && !MEM_WRITE_STROBE)[*5] ##1 MEM_DONE && !MEM_READ_STROBE)
    else $error("read cycle wrong");
  a_write_cycle: assert property (take && !MEM_REQ.read |=> MEM_WRITE_STROBE
    && MEM_DATA_OE[7:0] == 8'hFF
    && (MEM_DATA_OE[15:8] == {8{$past(MEM_REQ.wide && !MEM_REQ.boot)}}))
    else $error("write cycle wrong");
  a_one_target: assert property ((MEM_READ_STROBE || MEM_WRITE_STROBE) |->
    BOOT_ROM_SELECT != (RAM_SELECT_LOW_HALF || RAM_SELECT_HIGH_HALF))
    else $error("boot and ram selected together");
  a_wide_halves: assert property (take |=> RAM_SELECT_HIGH_HALF ==
    ($past(MEM_REQ.wide) && !$past(MEM_REQ.boot)) && BOOT_ROM_SELECT == $past(MEM_REQ.boot))
    else $error("half selects wrong");
  a_idle_release: assert property (ROM_LOADED && !SERIAL_ROM_SELECT && !MEM_WRITE_STROBE
    |-> MEM_DATA_OE == 16'h0000)
    else $error("data driven outside write");
endmodule
`default_nettype wire

// *** tb/memsup_far_model.sv ***
// far side model: serial rom and two ram halves on the data lines
`default_nettype none
module memsup_far_model
  import memsup_pkg::*;
(
  // design pins
  input  wire logic        clk,
  input  wire logic [15:0] dout,
  input  wire logic [15:0] doe,
  input  wire logic [7:0]  alo,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic        lo,
  input  wire logic        hi,
  input  wire logic        rcs,
  // drive back onto the data lines
  output logic      [15:0] en,
  output logic      [15:0] val,
  // a command bit that was not the read opcode
  output logic             cmd_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ram [0:15];
  logic [4:0]  cnt = 5'h00;
  logic [3:0]  wadr = 4'h0;
  logic        bad = 1'b0;
  wire logic   sk = rcs & doe[2] & dout[2];
  wire logic   sdo = doe[1] ? dout[1] : dout[0];
  wire logic [15:0] rword = 16'hC3A5 ^ (16'h1111 * {12'h000, wadr});
  // 3 command bits, 4 address bits, then 16 data bits msb first, each after a rising clock
  always @(posedge sk or negedge rcs) begin
    if (!rcs) begin
      cnt <= 5'h00;
    end else begin
      if (cnt < 5'h03 && sdo != ROM_READ_OP[2'h2 - cnt[1:0]]) bad <= 1'b1;
      if (cnt >= 5'h03 && cnt < 5'h07) wadr <= {wadr[2:0], sdo};
      cnt <= (cnt == 5'h16) ? 5'h00 : cnt + 5'h01;
    end
  end
  // ram halves take data on the strobe cycle and drive only while read and selected
  always @(posedge clk) begin
    if (wr && lo) ram[alo[3:0]][7:0] <= dout[7:0];
    if (wr && hi) ram[alo[3:0]][15:8] <= dout[15:8];
  end
  assign en = rcs ? {14'h0000, {2{cnt >= 5'h07}}} & ~doe : {{8{rd & hi}}, {8{rd & lo}}};
  assign val = rcs ? {14'h0000, {2{rword[5'h16 - cnt]}}} : ram[alo[3:0]];
  assign cmd_err = bad;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the memory support port
`default_nettype none
module testbench
  import memsup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        load = 1'b1;
  logic [15:0] strap = 16'hA55A;
  logic [7:0]  cin = 8'h3C;
  logic [3:0]  idx = 4'h0;
  mem_req_type req = '0;
  logic [15:0] dout, doe, en, val, rdata, word;
  logic [7:0]  alo;
  logic [6:0]  ahi;
  logic        aoe, rd, wr, bsel, lo, hi, rcs, ready, done, loaded, cmd_err;
  strap_type   straps;
  int          fail_count = 0;
  int          check_count = 0;
  // board wiring: device drive wins, then far side, else the strap resistors
  wire logic [15:0] din = (doe & dout) | (~doe & en & val) | (~doe & ~en & strap);
  always #10 CLK = ~CLK;
  memsup_port #(.HALF_CYC(8), .WORDS(16)) i_dut (
    .CLK(CLK), .RSTN(RSTN), .CE(1'b1), .LOAD_CFG_FROM_SERIAL_ROM(load),
    .MEM_DATA_IN(din), .MEM_DATA_OUT(dout), .MEM_DATA_OE(doe),
    .MEM_ADDR_LOW_IN(aoe ? alo : cin), .MEM_ADDR_LOW_LINES(alo), .MEM_ADDR_LOW_OE(aoe),
    .MEM_ADDR_HIGH_LINES(ahi), .MEM_READ_STROBE(rd), .MEM_WRITE_STROBE(wr),
    .BOOT_ROM_SELECT(bsel), .RAM_SELECT_LOW_HALF(lo), .RAM_SELECT_HIGH_HALF(hi),
    .SERIAL_ROM_SELECT(rcs), .MEM_REQ(req), .MEM_READY(ready), .MEM_DONE(done),
    .MEM_RDATA(rdata), .STRAPS(straps), .ROM_LOADED(loaded), .ROM_INDEX(idx), .ROM_WORD(word));
  memsup_far_model i_far (.clk(CLK), .dout(dout), .doe(doe), .alo(alo), .rd(rd), .wr(wr),
    .lo(lo), .hi(hi), .rcs(rcs), .en(en), .val(val), .cmd_err(cmd_err));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // f holds read, write, boot, wide, compat; waits on ready and done under a bound
  task automatic access(input logic [4:0] f, input logic [15:0] a, input logic [15:0] d);
    for (int n = 0; n < 50 && !ready; n++) @(posedge CLK) #1;
    req = {f, a, d};
    @(posedge CLK) #1;
    req = '0;
    for (int n = 0; n < 10 && !done; n++) @(posedge CLK) #1;
    check({15'h0000, done}, 16'h0001);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence: straps, serial load, ram traffic, second reset without load
  initial begin
    repeat (10) @(posedge CLK);
    #1;
    RSTN = 1'b1;
    strap = 16'h0F0F;
    cin = 8'hC3;
    for (int n = 0; n < 9000 && !loaded; n++) @(posedge CLK) #1;
    check({15'h0000, loaded}, 16'h0001);
    check({15'h0000, cmd_err}, 16'h0000);
    check({straps.bank_a, straps.bank_b}, 16'h5AA5);
    check({8'h00, straps.bank_c}, 16'h003C);
    check({rcs, doe[14:0]}, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      idx = i[3:0];
      #1;
      check(word, 16'hC3A5 ^ (16'h1111 * i[15:0]));
    end
    access(5'h0B, 16'h0006, 16'hBEEF);
    access(5'h13, 16'h0006, 16'h0000);
    check(rdata, 16'hBEEF);
    access(5'h1B, 16'h0006, 16'h1234);
    check(rdata, 16'hBEEF);
    access(5'h09, 16'h0009, 16'h0077);
    check({9'h000, ahi}, 16'h0010);
    access(5'h10, 16'h0009, 16'h0000);
    check({9'h000, ahi}, 16'h0040);
    check({8'h00, rdata[7:0]}, 16'h0077);
    access(5'h14, 16'h0010, 16'h0000);
    check(rdata, 16'h0F0F);
    RSTN = 1'b0;
    load = 1'b0;
    strap = 16'h00FF;
    repeat (10) @(posedge CLK);
    #1;
    RSTN = 1'b1;
    repeat (20) @(posedge CLK);
    #1;
    check({straps.bank_a, 7'h00, rcs}, 16'hFF00);
    check({15'h0000, ready}, 16'h0001);
    final_report();
  end

  // cut a hang short: the run needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    final_report();
  end
endmodule

bind memsup_port memsup_port_properties i_props (.CLK(CLK), .RSTN(RSTN), .CE(CE),
  .MEM_REQ(MEM_REQ), .MEM_READY(MEM_READY), .MEM_DONE(MEM_DONE), .MEM_DATA_OE(MEM_DATA_OE),
  .MEM_ADDR_LOW_LINES(MEM_ADDR_LOW_LINES), .MEM_ADDR_HIGH_LINES(MEM_ADDR_HIGH_LINES),
  .MEM_READ_STROBE(MEM_READ_STROBE), .MEM_WRITE_STROBE(MEM_WRITE_STROBE),
  .BOOT_ROM_SELECT(BOOT_ROM_SELECT), .RAM_SELECT_LOW_HALF(RAM_SELECT_LOW_HALF),
  .RAM_SELECT_HIGH_HALF(RAM_SELECT_HIGH_HALF), .SERIAL_ROM_SELECT(SERIAL_ROM_SELECT),
  .ROM_LOADED(ROM_LOADED), .STRAPS(STRAPS));
`default_nettype wire
